// ---- pkg/stm_pkg.sv ----
// Package for the 10-bit standard timer: register offsets, fields, modes.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package stm_pkg;
  localparam int CNT_W = 10;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL0 = 5'h00;
  localparam logic [4:0] OFF_CTRL1 = 5'h04;
  localparam logic [4:0] OFF_CNT_LO = 5'h08;
  localparam logic [4:0] OFF_CNT_HI = 5'h0C;
  localparam logic [4:0] OFF_CMP_LO = 5'h10;
  localparam logic [4:0] OFF_CMP_HI = 5'h14;
  localparam logic [4:0] OFF_FLAGS = 5'h18;
  // Control 0 fields
  localparam int C0_PAUSE = 7;
  localparam int C0_CLK_LSB = 4;
  localparam int C0_ON = 3;
  // Control 1 fields
  localparam int C1_MODE_LSB = 6;
  localparam int C1_PIN_LSB = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_DPX = 1;
  localparam int C1_CCLR = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // Clock selects
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;
  localparam logic [5:0] DIV_SYS4 = 6'h03;
  localparam logic [5:0] DIV_H16 = 6'h0F;
  localparam logic [5:0] DIV_H64 = 6'h3F;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  // Coarse compare at zero means a full period of this many clocks
  localparam logic [10:0] FULL_PERIOD = 11'h400;
endpackage

// ---- rtl/stm_timer.sv ----
// 10-bit standard timer with coarse and fine comparators and Wishbone registers.
// Assumes sub and high clocks arrive as enable pulses on clk_i; pins are async.
// Functional notes
// - ten-bit up-counter on selected clock
// - coarse compares bits 9..7, fine all ten
// - on bit rising edge zeroes the counter
// - on bit low stops, counter holds value
// - pause bit freezes counter, clear resumes
// - clock select picks prescaled, sub, external edge
// - coarse period is field times 128, zero 1024
// - coarse field zero clears at overflow
// - mode field selects compare, capture, PWM, timer
// - fine match drives none, low, high, toggle
// - PWM pin field: inactive, active, PWM, pulse
// - capture edge rising, falling, both, disabled
// - on rising restores initial compare output level
// - output control sets initial or active level
// - polarity bit inverts timer output pin
// - duty period bit swaps comparator roles
// - clear select picks fine or coarse clear
// - counter clears on overflow or match, flags
// - complementary pin is inverse of output
// - timer mode leaves output pin undriven
// - clear select high sets no coarse flag except in PWM mode
// - low bytes pass through an 8-bit buffer
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module stm_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic high_clk_en_i,
  input wire logic sub_clk_en_i,
  input wire logic external_clock_pin_i,
  input wire logic capture_input_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_oe_o,
  output logic complementary_output_pin_o,
  output logic fine_match_o,
  output logic coarse_match_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Theory of operation
  //
  // Count clock
  //   Every register runs on clk_i; the count clock is a one-cycle tick.
  //   A free-running prescaler makes the divided system rates.
  //   High-clock rates advance the prescaler only on high-clock pulses,
  //   so the division is counted in high-clock periods, not system cycles.
  //   Sub clock enables are used as ticks directly.
  //   External edges come from the synchronised pin, three cycles late;
  //   an external clock faster than half of clk_i loses edges.
  //
  // Counter
  //   Ten bits, counting up on each tick while on and not paused.
  //   The on bit rising zeroes it; nothing else written by software can.
  //   Switching off or pausing freezes it and every event with it.
  //
  // Comparators
  //   Both matches fire on the tick that leaves the value one below the
  //   compare point, so that a clear gives a period of exactly that many
  //   ticks. A fine value of zero never matches, which keeps the
  //   compare-match output from firing on the overflow wrap.
  //   The coarse field looks only at the top three counter bits, so its
  //   periods are multiples of 128 ticks; zero means the full 1024.
  //
  // Clearing
  //   Compare and timer modes: clear select picks fine or coarse/overflow.
  //   With the fine clear only the fine flag is ever raised.
  //   PWM mode: the duty/period bit picks which comparator ends a period.
  //
  // Output pin
  //   One registered raw level, inverted by the polarity bit on the way
  //   out; the complementary pin is always its inverse.
  //   Compare mode: the on bit rising restores the initial level, and a
  //   match then drives low, high or toggles per the pin field.
  //   PWM mode: forced inactive, forced active, waveform or single pulse.
  //   The waveform is active while the counter is below the duty value,
  //   so a duty at or above the period gives a full active level.
  //   Single pulse: an external rising edge zeroes the counter and starts
  //   one active period, ended by the period clear.
  //   Capture and timer modes release the pin through the enable.
  //
  // Capture
  //   The counter is copied on the selected pin edge and the fine flag is
  //   raised; the counter high byte read returns the captured value then.
  //
  // Register access
  //   Low bytes go through one shared eight-bit buffer: a high-byte read
  //   fills it, a high-byte write empties it into the compare value.
  //   Software must not mix the two sequences, since they share it.
  //   Flags are write-one-to-clear; an event in the same cycle wins.
  //
  // Limitations
  //   Mode and pin function changes are expected only while switched off;
  //   changing them while running gives an undefined waveform for a period.
  //   There is no interrupt output; the match pulses serve instead.

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] cnt;
    logic [9:0] cmp;
    logic [7:0] buf_lo;
    logic [9:0] cap;
    logic [5:0] pre;
    logic on_q;
    logic out_raw;
    logic pulse_run;
    logic fine_flag;
    logic coarse_flag;
    logic fine_p;
    logic coarse_p;
    logic [1:0] ext_s;
    logic ext_q;
    logic [1:0] cap_s;
    logic cap_q;
    logic ack;
    logic [31:0] rdat;
  } stm_state_t;

  stm_state_t s;
  stm_state_t next_s;

  logic tick;
  logic [1:0] mode;
  logic [1:0] pinf;
  logic [2:0] coarse;
  logic coarse_hit;
  logic fine_hit;
  logic overflow;
  logic clr;
  logic running;
  logic ext_rise;
  logic ext_fall;
  logic cap_edge;
  logic cap_hit;
  logic [10:0] period;
  logic [10:0] duty;
  logic on_rise;
  logic wr;
  logic rd;
  logic active_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s = s;
    // Defaults keep the capture decode free of latches
    cap_edge = 1'b0;
    cap_hit = 1'b0;
    mode = s.ctrl1[stm_pkg::C1_MODE_LSB +: 2];
    pinf = s.ctrl1[stm_pkg::C1_PIN_LSB +: 2];
    coarse = s.ctrl0[2:0];
    active_lvl = s.ctrl1[stm_pkg::C1_OC];
    on_rise = s.ctrl0[stm_pkg::C0_ON] & ~s.on_q;
    running = s.ctrl0[stm_pkg::C0_ON] & ~s.ctrl0[stm_pkg::C0_PAUSE];
    // Synchronisers: first stage only feeds the second
    next_s.ext_s = {s.ext_s[0], external_clock_pin_i};
    next_s.ext_q = s.ext_s[1];
    next_s.cap_s = {s.cap_s[0], capture_input_pin_i};
    next_s.cap_q = s.cap_s[1];
    ext_rise = s.ext_s[1] & ~s.ext_q;
    ext_fall = ~s.ext_s[1] & s.ext_q;
    // Prescaler free-runs so the divided rates stay phase-stable
    next_s.pre = s.pre + 6'h01;
    case (s.ctrl0[stm_pkg::C0_CLK_LSB +: 3])
      stm_pkg::CK_SYS4: tick = (s.pre & stm_pkg::DIV_SYS4) == stm_pkg::DIV_SYS4;
      stm_pkg::CK_SYS: tick = 1'b1;
      stm_pkg::CK_H16: tick = high_clk_en_i & ((s.pre & stm_pkg::DIV_H16) == stm_pkg::DIV_H16);
      stm_pkg::CK_H64: tick = high_clk_en_i & ((s.pre & stm_pkg::DIV_H64) == stm_pkg::DIV_H64);
      stm_pkg::CK_EXTR: tick = ext_rise;
      stm_pkg::CK_EXTF: tick = ext_fall;
      default: tick = sub_clk_en_i;
    endcase
    if (high_clk_en_i == 1'b0 && (s.ctrl0[6:4] == stm_pkg::CK_H16 ||
        s.ctrl0[6:4] == stm_pkg::CK_H64)) begin
      next_s.pre = s.pre; // High-clock dividers count only high-clock pulses
    end
    // Comparators: match when the counter is about to leave the value
    coarse_hit = (coarse != 3'h0) && (s.cnt == {coarse - 3'h1, 7'h7F});
    fine_hit = (s.cnt == s.cmp - 10'h001) && (s.cmp != 10'h000);
    overflow = (s.cnt == stm_pkg::CNT_MAX);
    period = (coarse == 3'h0) ? stm_pkg::FULL_PERIOD : {coarse, 8'h00} >> 1;
    if (s.ctrl1[stm_pkg::C1_DPX]) begin
      duty = period;
      period = {1'b0, s.cmp};
    end else begin
      duty = {1'b0, s.cmp};
    end
    next_s.fine_p = 1'b0;
    next_s.coarse_p = 1'b0;
    clr = 1'b0;
    if (running && tick) begin
      if (mode == stm_pkg::MODE_PWM) begin
        clr = s.ctrl1[stm_pkg::C1_DPX] ? fine_hit : (coarse_hit | (coarse == 3'h0 && overflow));
        next_s.fine_p = fine_hit;
        next_s.coarse_p = coarse_hit;
      end else if (s.ctrl1[stm_pkg::C1_CCLR]) begin
        clr = fine_hit | overflow;
        next_s.fine_p = fine_hit;
      end else begin
        clr = coarse_hit | (coarse == 3'h0 && overflow);
        next_s.fine_p = fine_hit;
        next_s.coarse_p = coarse_hit | (coarse == 3'h0 && overflow);
      end
      next_s.cnt = clr ? 10'h000 : s.cnt + 10'h001;
    end
    if (next_s.fine_p) begin
      next_s.fine_flag = 1'b1;
    end
    if (next_s.coarse_p) begin
      next_s.coarse_flag = 1'b1;
    end
    // Output waveform per mode
    case (mode)
      stm_pkg::MODE_CMP: begin
        if (next_s.fine_p) begin
          case (pinf)
            2'h1: next_s.out_raw = 1'b0;
            2'h2: next_s.out_raw = 1'b1;
            2'h3: next_s.out_raw = ~s.out_raw;
            default: next_s.out_raw = s.out_raw;
          endcase
        end
      end
      stm_pkg::MODE_PWM: begin
        if (running) begin
          case (pinf)
            2'h0: next_s.out_raw = ~active_lvl;
            2'h1: next_s.out_raw = active_lvl;
            2'h2: next_s.out_raw = ({1'b0, next_s.cnt} < duty) ? active_lvl : ~active_lvl;
            default: begin
              // Single pulse: one active period started by an external rising edge
              if (ext_rise && !s.pulse_run) begin
                next_s.pulse_run = 1'b1;
                next_s.cnt = 10'h000;
              end else if (s.pulse_run && tick && clr) begin
                next_s.pulse_run = 1'b0;
              end
              next_s.out_raw = next_s.pulse_run ? active_lvl : ~active_lvl;
            end
          endcase
        end
      end
      stm_pkg::MODE_CAP: begin
        case (pinf)
          2'h0: cap_edge = s.cap_s[1] & ~s.cap_q;
          2'h1: cap_edge = ~s.cap_s[1] & s.cap_q;
          2'h2: cap_edge = s.cap_s[1] ^ s.cap_q;
          default: cap_edge = 1'b0;
        endcase
        if (running && cap_edge) begin
          next_s.cap = s.cnt;
          cap_hit = 1'b1;
          next_s.fine_flag = 1'b1;
        end
      end
      default: begin
        next_s.out_raw = s.out_raw;
      end
    endcase
    if (on_rise) begin
      next_s.cnt = 10'h000;
      next_s.pulse_run = 1'b0;
      if (mode == stm_pkg::MODE_CMP) begin
        next_s.out_raw = active_lvl;
      end
    end
    next_s.on_q = s.ctrl0[stm_pkg::C0_ON];
    // Wishbone slave: one wait state, ack drops the cycle after
    wr = wb_cyc_i & wb_stb_i & ~s.ack & wb_we_i & wb_sel_i[0];
    rd = wb_cyc_i & wb_stb_i & ~s.ack & ~wb_we_i;
    next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    next_s.rdat = 32'h0000_0000;
    if (wr) begin
      case (wb_adr_i)
        stm_pkg::OFF_CTRL0: next_s.ctrl0 = wb_dat_i[7:0];
        stm_pkg::OFF_CTRL1: next_s.ctrl1 = wb_dat_i[7:0];
        stm_pkg::OFF_CMP_LO: next_s.buf_lo = wb_dat_i[7:0];
        stm_pkg::OFF_CMP_HI: next_s.cmp = {wb_dat_i[1:0], s.buf_lo};
        stm_pkg::OFF_FLAGS: begin
          // Write one to clear; a same-cycle event keeps the flag set
          next_s.fine_flag = (s.fine_flag & ~wb_dat_i[0]) | next_s.fine_p | cap_hit;
          next_s.coarse_flag = (s.coarse_flag & ~wb_dat_i[1]) | next_s.coarse_p;
        end
        default: next_s.ack = next_s.ack;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        stm_pkg::OFF_CTRL0: next_s.rdat = {24'h000000, s.ctrl0};
        stm_pkg::OFF_CTRL1: next_s.rdat = {24'h000000, s.ctrl1};
        stm_pkg::OFF_CNT_LO: next_s.rdat = {24'h000000, s.buf_lo};
        stm_pkg::OFF_CNT_HI: begin
          next_s.rdat = {30'h00000000, mode == stm_pkg::MODE_CAP ? s.cap[9:8] : s.cnt[9:8]};
          next_s.buf_lo = (mode == stm_pkg::MODE_CAP) ? s.cap[7:0] : s.cnt[7:0];
        end
        stm_pkg::OFF_CMP_LO: next_s.rdat = {24'h000000, s.buf_lo};
        stm_pkg::OFF_CMP_HI: begin
          next_s.rdat = {30'h00000000, s.cmp[9:8]};
          next_s.buf_lo = s.cmp[7:0];
        end
        stm_pkg::OFF_FLAGS: next_s.rdat = {30'h00000000, s.coarse_flag, s.fine_flag};
        default: next_s.rdat = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; pin is released in timer/counter and capture modes
  assign timer_output_pin_o = s.out_raw ^ s.ctrl1[stm_pkg::C1_POL];
  assign complementary_output_pin_o = ~timer_output_pin_o;
  assign timer_output_oe_o = (mode == stm_pkg::MODE_CMP) || (mode == stm_pkg::MODE_PWM);
  assign fine_match_o = s.fine_p;
  assign coarse_match_o = s.coarse_p;
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;

endmodule
`default_nettype wire

// ---- tb/stm_timer_asserts.sv ----
// Checker for the standard timer: bus handshake, output pins, match events.
// Assumes it is bound to stm_timer and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module stm_timer_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_oe_o,
  input wire logic complementary_output_pin_o,
  input wire logic fine_match_o,
  input wire logic coarse_match_o
);
  logic [7:0] c0;
  logic [7:0] c1;
  logic idle;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the control registers, taken at the edge where a write lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]) begin
      if (wb_adr_i == stm_pkg::OFF_CTRL0) c0 <= wb_dat_i[7:0];
      if (wb_adr_i == stm_pkg::OFF_CTRL1) c1 <= wb_dat_i[7:0];
    end
  end
  // Off or paused; the past terms below leave room for the match pipeline
  assign idle = !c0[3] || c0[7];
  ////////////////////////////////////////////////////////////////////////////
  a_pin_inverse: assert property (complementary_output_pin_o == !timer_output_pin_o)
    else $error("complement pin equals output pin");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside answer cycle");
  a_coarse_spacing: assert property (coarse_match_o |=> !coarse_match_o [*8])
    else $error("coarse events too close");
  a_fine_clear_only: assert property (c1[0] && $past(c1[0]) && c1[7] == c1[6]
    |-> !coarse_match_o) else $error("coarse event with fine clear");
  a_idle_quiet: assert property (idle && $past(idle) && $past(idle, 2)
    && c1[7:6] != stm_pkg::MODE_CAP |-> !fine_match_o && !coarse_match_o)
    else $error("event while stopped");
  a_oe_mode: assert property (c1[7:6] == $past(c1[7:6]) |-> timer_output_oe_o ==
    (c1[7:6] == stm_pkg::MODE_CMP || c1[7:6] == stm_pkg::MODE_PWM)) else $error("bad enable");
  a_on_restore: assert property (c0[3] && !$past(c0[3]) && c1[7:6] == stm_pkg::MODE_CMP
    |-> ##[0:2] timer_output_pin_o == (c1[3] ^ c1[2])) else $error("initial level lost");
endmodule
bind stm_timer stm_timer_asserts u_stm_timer_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_output_pin_o(timer_output_pin_o), .timer_output_oe_o(timer_output_oe_o),
  .complementary_output_pin_o(complementary_output_pin_o),
  .fine_match_o(fine_match_o), .coarse_match_o(coarse_match_o));
`default_nettype wire

// ---- tb/stm_pins_model.sv ----
// Far-side pins: an external count clock and a capture input source.
// Assumes the bench clock; the count clock stands still unless run_i is high.
`timescale 1ns/1ns
`default_nettype none
module stm_pins_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic cap_go_i,
  output logic ext_clk_o,
  output logic cap_o
);
  logic [1:0] ph = 2'h0;
  logic [2:0] hold = 3'h0;
  initial ext_clk_o = 1'b0;
  // Count clock of eight cycles; a capture pulse six cycles wide
  always @(posedge clk_i) begin
    ph <= ph + 2'h1;
    if (run_i && ph == 2'h3) ext_clk_o <= !ext_clk_o;
    if (cap_go_i) hold <= 3'h6;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  assign cap_o = (hold != 3'h0);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for the standard timer: register tests over the bus and pin checks.
// Assumes the checker is bound in and the pin model drives the input pins.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
  logic wb_ack_o, pin_o, pinb_o, ext_pin, cap_pin, oe, fm, cm;
  int fm_cnt = 0;
  logic high_en = 1'b0, sub_en = 1'b0, ext_run = 1'b0, cap_go = 1'b0;
  logic [1:0] div = 2'h0;
  logic [7:0] q;
  logic [15:0] v1, v2;
  logic [15:0] exp_p [8] = '{16'h0200, 16'h0080, 16'h1000, 16'h4000,
    16'h0200, 16'h0200, 16'h0400, 16'h0400};
  int num_errors = 0, num_checks = 0, cycles = 0, n;
  always #5 clk_i = ~clk_i;
  stm_timer u_stm_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .high_clk_en_i(high_en), .sub_clk_en_i(sub_en), .external_clock_pin_i(ext_pin),
    .capture_input_pin_i(cap_pin), .timer_output_pin_o(pin_o), .timer_output_oe_o(oe),
    .complementary_output_pin_o(pinb_o), .fine_match_o(fm), .coarse_match_o(cm));
  stm_pins_model u_stm_pins_model (.clk_i(clk_i), .run_i(ext_run), .cap_go_i(cap_go),
    .ext_clk_o(ext_pin), .cap_o(cap_pin));
  ////////////////////////////////////////////////////////////////////////////
  // High clock enable every other cycle, sub clock every fourth; timeout
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    high_en <= div[0];
    sub_en <= (div == 2'h3);
    cycles <= cycles + 1;
    if (fm === 1'b1) fm_cnt <= fm_cnt + 1;
    if (cycles == 80000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // High byte first so the low byte comes from the same instant
  task automatic rdcnt(output logic [15:0] v);
    xfer(1'b0, 5'h0C, 8'h00);
    v[15:8] = q;
    xfer(1'b0, 5'h08, 8'h00);
    v[7:0] = q;
  endtask
  // Off before mode and pin changes, flags cleared, then on
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
    xfer(1'b1, 5'h00, c0 & 8'hF7);
    xfer(1'b1, 5'h04, c1);
    xfer(1'b1, 5'h18, 8'h03);
    xfer(1'b1, 5'h00, c0);
  endtask
  // Cycles between two coarse events, timed from the outside
  task automatic period(input logic [15:0] exp);
    n = 0;
    do @(posedge clk_i); while (cm !== 1'b1);
    do begin
      @(posedge clk_i);
      n++;
    end while (cm !== 1'b1);
    chk(n[15:0], exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(5'h00, 8'h00);
    rd(5'h04, 8'h00);
    rd(5'h08, 8'h00);
    rd(5'h1C, 8'h00);
    xfer(1'b1, 5'h10, 8'h05);
    xfer(1'b1, 5'h14, 8'h00);
    xfer(1'b1, 5'h10, 8'hAA);
    rd(5'h14, 8'h00);
    rd(5'h10, 8'h05);
    cfg(8'hC0, 8'h18);
    repeat (300) @(posedge clk_i);
    xfer(1'b1, 5'h00, 8'h10);
    rdcnt(v1);
    repeat (50) @(posedge clk_i);
    rdcnt(v2);
    chk(v1[15:8], 16'h0001);
    chk(v2, v1);
    xfer(1'b1, 5'h00, 8'h18);
    rdcnt(v1);
    chk(v1 < 16'h0010, 16'h0001);
    xfer(1'b1, 5'h00, 8'h98);
    rdcnt(v1);
    repeat (50) @(posedge clk_i);
    rdcnt(v2);
    chk(v2, v1);
    xfer(1'b1, 5'h00, 8'h18);
    repeat (40) @(posedge clk_i);
    rdcnt(v2);
    chk(v2 - v1 > 16'h0028 && v2 - v1 < 16'h0040, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      ext_run <= (i > 5);
      cfg(8'hC0, {1'b0, i[2:0], 4'h9});
      period(exp_p[i]);
    end
    cfg(8'hC0, 8'h18);
    period(16'h0400);
    for (int f = 0; f < 4; f++) begin
      for (int p = 0; p < 2; p++) begin
        cfg({2'b00, f[1:0], 1'b0, p[0], 2'b01}, 8'h18);
        repeat (10) @(posedge clk_i);
        n = fm_cnt;
        repeat (30) @(posedge clk_i);
        chk(fm_cnt - n, 16'h0006);
        chk(oe, 1'b1);
        if (f < 3) chk(pin_o, (f == 2) ^ p[0]);
        chk(pinb_o, !pin_o);
        rd(5'h18, 8'h01);
        rdcnt(v1);
        chk(v1 < 16'h0005, 16'h0001);
      end
    end
    for (int f = 0; f < 4; f++) begin
      cfg({2'b10, f[1:0], 4'h8}, 8'h18);
      repeat (60) @(posedge clk_i);
      chk(pin_o, f == 1 || f == 3);
    end
    xfer(1'b1, 5'h10, 8'h00);
    xfer(1'b1, 5'h14, 8'h00);
    for (int f = 0; f < 4; f++) begin
      cfg({2'b01, f[1:0], 4'h0}, 8'h18);
      cap_go <= 1'b1;
      @(posedge clk_i);
      cap_go <= 1'b0;
      repeat (30) @(posedge clk_i);
      rd(5'h18, {7'h00, f < 3});
      chk(oe, 1'b0);
    end
    final_report();
  end
endmodule
`default_nettype wire
